// [hw/nirq_unit.sv]
// Our own choice: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module nirq_unit
    import nirq_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    input  wire logic        WB_CYC,
    input  wire logic        WB_STB,
    input  wire logic        WB_WE,
    input  wire logic [9:0]  WB_ADR,
    input  wire logic [3:0]  WB_SEL,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK,
    input  wire logic [7:0]  EXT_PIN,
    input  wire logic        NMI_PIN,
    input  wire logic        TIMER_IRQ,
    input  wire logic        CLKU_IRQ,
    input  wire logic        WDG_EOC,
    input  wire logic        CPU_ACK,
    input  wire logic        CPU_IRET,
    input  wire logic        CPU_EN_IRQ,
    input  wire logic        CPU_DI,
    output logic             IRQ_REQ,
    output logic             IRQ_TOP,
    output logic      [7:0]  IRQ_VECTOR,
    output var nirq_seq_t    SEQ_STEP,
    output logic             SEG_LOAD,
    output logic             FETCH_IRQ_SEG
);

    // ------------------------------------------------------------
    // whole state of the unit
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] run_lvl;
        logic       gie;
        logic       top_men;
        logic       top_pnd;
        logic       mode;
        logic       sse;
        logic [6:0] stk;
        logic       top_nme;
        logic [7:0] edg;
        logic [7:0] pend;
        logic [7:0] msk;
        logic [7:0] prio;
        logic [7:0] vsel;
        logic [8:0] s1;
        logic [8:0] s2;
        logic [8:0] s3;
        logic       top_act;
        logic       irq_seg;
        logic [3:0] depth;
        nirq_seq_t  seq;
        logic       req;
        logic       req_top;
        logic [2:0] req_lvl;
        logic [2:0] req_ch;
        logic [7:0] vec;
        logic       ack;
        logic [7:0] rdat;
    } nirq_st_t;

    nirq_st_t r_reg;
    nirq_st_t r_next;
    logic     take;
    logic     wr_now;
    logic     top_ok;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic [8:0] rise;
        logic [8:0] fall;
        logic [7:0] ev;
        logic       top_ev;
        logic       win;
        logic       ext_ok;
        logic [2:0] wl;
        logic [2:0] wc;
        logic [2:0] lvl;
        logic [7:0] idx;
        logic [7:0] wd;
        logic [3:0] dleft;
        r_next = r_reg;
        top_ev = 1'b0;
        ext_ok = 1'b0;
        rise   = r_reg.s2 & ~r_reg.s3;
        fall   = ~r_reg.s2 & r_reg.s3;
        ev     = '0;
        win    = 1'b0;
        wl     = 3'h7;
        wc     = 3'h0;
        lvl    = 3'h0;
        idx    = WB_ADR[9:2];
        wd     = WB_DAT_I[7:0];
        dleft  = r_reg.depth - 4'h1;

        // two-flop synchronisers, third stage only for edges
        r_next.s1 = {NMI_PIN, EXT_PIN};
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;

        // pin edges chosen per channel, eight channels in four pairs [RULE13]
        for (int i = 0; i < 8; i++)
        begin
            ev[i] = r_reg.edg[i] ? rise[i] : fall[i]; // [RULE14]
        end
        if (!r_reg.vsel[NIRQ_VS_A0])
        begin
            ev[NIRQ_CH_A0] = TIMER_IRQ; // [RULE17]
        end
        if (r_reg.vsel[NIRQ_VS_D0])
        begin
            ev[NIRQ_CH_D0] = CLKU_IRQ; // [RULE18]
        end
        top_ev = r_reg.vsel[NIRQ_VS_TSRC]                              // [RULE19]
               ? (r_reg.vsel[NIRQ_VS_TEDGE] ? rise[8] : fall[8])   // [RULE20]
               : WDG_EOC;

        // lowest level wins; lower channel index wins a tie (daisy chain)
        for (int i = 0; i < 8; i++)
        begin
            lvl = {r_reg.prio[6 - 2 * (i / 2) +: 2], 1'(i % 2)}; // [RULE16]
            if (r_reg.pend[i] && r_reg.msk[7 - i] && (!win || lvl < wl)) // [RULE15]
            begin
                win = 1'b1;
                wl  = lvl;
                wc  = 3'(i);
            end
        end
        top_ok = r_reg.top_pnd && !r_reg.top_act                    // [RULE24]
               && ((r_reg.top_men && r_reg.gie) || r_reg.top_nme);  // [RULE22] [RULE23]
        ext_ok = win && r_reg.gie && (wl < r_reg.run_lvl) && !r_reg.top_act; // [RULE1]
        r_next.req     = (top_ok || ext_ok) && (r_reg.seq == NIRQ_IDLE);
        r_next.req_top = top_ok;
        r_next.req_lvl = wl;
        r_next.req_ch  = wc;
        r_next.vec     = top_ok ? NIRQ_TOP_VEC : {r_reg.vsel[7:4], wc, 1'b0};

        // ack only if the offered winner still stands this cycle
        take = CPU_ACK && r_reg.req && (r_reg.seq == NIRQ_IDLE)
             && (r_reg.req_top ? top_ok : (!top_ok && ext_ok && wc == r_reg.req_ch));

        // bus slave: one wait state, write lands on the ack edge
        wr_now      = WB_CYC && WB_STB && WB_WE && r_reg.ack && WB_SEL[0];
        r_next.ack  = WB_CYC && WB_STB && !r_reg.ack;
        if (WB_CYC && WB_STB && !r_reg.ack)
        begin
            case (idx)
                NIRQ_IDX_CENTRAL: r_next.rdat = {r_reg.mode, r_reg.top_pnd, r_reg.top_men,
                                                 r_reg.gie, r_reg.sse, r_reg.run_lvl};
                NIRQ_IDX_EDGE:    r_next.rdat = r_reg.edg;
                NIRQ_IDX_PEND:    r_next.rdat = r_reg.pend;
                NIRQ_IDX_MASK:    r_next.rdat = r_reg.msk;
                NIRQ_IDX_PRIO:    r_next.rdat = r_reg.prio;
                NIRQ_IDX_VSEL:    r_next.rdat = r_reg.vsel;
                NIRQ_IDX_STACK:   r_next.rdat = {r_reg.top_nme, r_reg.stk};
                default:          r_next.rdat = 8'h00;
            endcase
        end
        if (wr_now)
        begin
            case (idx)
                NIRQ_IDX_CENTRAL:
                begin
                    r_next.run_lvl = wd[2:0];
                    r_next.sse     = wd[NIRQ_CTL_SSE];
                    r_next.gie     = wd[NIRQ_CTL_GIE];
                    r_next.top_men = wd[NIRQ_CTL_TME];
                    r_next.top_pnd = wd[NIRQ_CTL_TPND];
                    r_next.mode    = wd[NIRQ_CTL_MODE];
                end
                NIRQ_IDX_EDGE:  r_next.edg  = wd;
                NIRQ_IDX_PEND:  r_next.pend = wd;
                NIRQ_IDX_MASK:  r_next.msk  = wd;
                NIRQ_IDX_PRIO:  r_next.prio = wd;
                NIRQ_IDX_VSEL:  r_next.vsel = wd;
                NIRQ_IDX_STACK:
                begin
                    r_next.stk     = wd[6:0];
                    r_next.top_nme = r_reg.top_nme | wd[NIRQ_STK_TNME]; // [RULE23]
                end
                default: ;
            endcase
        end

        // core instructions for the global enable
        if (CPU_EN_IRQ)
        begin
            r_next.gie = 1'b1;
        end
        if (CPU_DI)
        begin
            r_next.gie = 1'b0;
        end

        // acknowledge: the level swap happens before any push
        if (take)
        begin
            r_next.seq = NIRQ_PCL;
            r_next.depth = (r_reg.depth == 4'hf) ? r_reg.depth : r_reg.depth + 4'h1;
            r_next.irq_seg = !r_reg.sse; // [RULE7]
            if (r_reg.req_top)
            begin
                r_next.top_act = 1'b1;  // [RULE25]
                r_next.top_pnd = 1'b0;
            end
            else
            begin
                r_next.gie = 1'b0; // [RULE6]
                r_next.pend[r_reg.req_ch] = 1'b0;
                if (r_reg.mode) // [RULE3]
                begin
                    if (r_reg.run_lvl != NIRQ_LVL_RST)
                    begin
                        r_next.stk[r_reg.run_lvl] = 1'b1; // [RULE4]
                    end
                    r_next.run_lvl = r_reg.req_lvl; // [RULE5]
                end
            end
        end

        // push, vector load, then the pop order of the return
        case (r_reg.seq)
            NIRQ_IDLE: if (CPU_IRET && !take) r_next.seq = NIRQ_RFLG;
            NIRQ_PCL:  r_next.seq = NIRQ_PCH; // [RULE6]
            NIRQ_PCH:  r_next.seq = r_reg.sse ? NIRQ_SEG : NIRQ_FLG;
            NIRQ_SEG:  r_next.seq = NIRQ_FLG;
            NIRQ_FLG:  r_next.seq = NIRQ_VEC;
            NIRQ_VEC:  r_next.seq = NIRQ_IDLE;
            NIRQ_RFLG: r_next.seq = r_reg.sse ? NIRQ_RSEG : NIRQ_RPCH; // [RULE8]
            NIRQ_RSEG: r_next.seq = NIRQ_RPCH;
            NIRQ_RPCH: r_next.seq = NIRQ_RPCL;
            NIRQ_RPCL: r_next.seq = NIRQ_REND;
            NIRQ_REND:
            begin
                r_next.seq   = NIRQ_IDLE;
                r_next.depth = (r_reg.depth == 4'h0) ? r_reg.depth : dleft;
                // stay on the irq segment only when returning into a nested routine
                r_next.irq_seg = !r_reg.sse && r_reg.mode && r_reg.depth > 4'h1; // [RULE10]
                if (r_reg.top_act)
                begin
                    r_next.top_act = 1'b0; // [RULE25]
                end
                else
                begin
                    r_next.gie = 1'b1; // [RULE8]
                    if (r_reg.mode)
                    begin
                        r_next.run_lvl = NIRQ_LVL_RST;
                        for (int i = 6; i >= 0; i--)
                        begin
                            if (r_reg.stk[i])
                            begin
                                r_next.run_lvl = 3'(i); // [RULE9]
                            end
                        end
                        r_next.stk = r_reg.stk & (r_reg.stk - 7'h01); // [RULE9]
                    end
                end
            end
            default: r_next.seq = NIRQ_IDLE;
        endcase

        // hardware sets come last so they win over any clear
        r_next.pend = r_next.pend | ev; // [RULE14]
        if (top_ev)
        begin
            r_next.top_pnd = 1'b1; // [RULE21]
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            r_reg      <= '0;
            r_reg.run_lvl <= NIRQ_LVL_RST; // [RULE2]
            r_reg.vsel <= NIRQ_VSEL_RST;
            r_reg.seq  <= NIRQ_IDLE;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // outputs; request is withdrawn as soon as a sequence starts
    assign IRQ_REQ       = r_reg.req && (r_reg.seq == NIRQ_IDLE);
    assign IRQ_TOP       = r_reg.req_top;
    assign IRQ_VECTOR    = r_reg.vec;
    assign SEQ_STEP      = r_reg.seq;
    assign SEG_LOAD      = (r_reg.seq == NIRQ_VEC) && r_reg.sse; // [RULE7]
    assign FETCH_IRQ_SEG = r_reg.irq_seg;
    assign WB_ACK        = r_reg.ack;
    assign WB_DAT_O      = {24'h00_0000, r_reg.rdat};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    sequence s_push_pc;
        (r_reg.seq == NIRQ_PCL) ##1 (r_reg.seq == NIRQ_PCH);
    endsequence
    sequence s_push_rest;
        (r_reg.seq == NIRQ_SEG || r_reg.seq == NIRQ_FLG) ##[1:2] (r_reg.seq == NIRQ_VEC);
    endsequence

    a_entry_order: assert property (take |=> s_push_pc ##1 s_push_rest) // [RULE6]
        else $error("entry sequence out of order");
    a_ack_strict: assert property (take && !r_reg.req_top |-> r_reg.req_lvl < r_reg.run_lvl) // [RULE1]
        else $error("request taken at or above current level");
    a_concur_hold: assert property (take && !r_reg.mode && !wr_now |=> $stable(r_reg.run_lvl)) // [RULE3]
        else $error("level changed in concurrent mode");
    a_stack_save: assert property (take && r_reg.mode && !r_reg.req_top && !wr_now // [RULE4]
        && r_reg.run_lvl != NIRQ_LVL_RST |=> r_reg.stk[$past(r_reg.run_lvl)])
        else $error("running level not saved");
    a_level_swap: assert property (take && r_reg.mode && !r_reg.req_top && !wr_now // [RULE5]
        |=> r_reg.run_lvl == $past(r_reg.req_lvl))
        else $error("level not replaced");
    a_top_keep: assert property (take && r_reg.req_top && !wr_now && !CPU_EN_IRQ && !CPU_DI // [RULE25]
        |=> $stable(r_reg.gie) && $stable(r_reg.run_lvl) && $stable(r_reg.stk))
        else $error("top entry touched enable or level");
    a_top_blocks: assert property (r_reg.top_act |-> !IRQ_REQ) // [RULE24]
        else $error("request offered during top routine");
    a_ret_enable: assert property (r_reg.seq == NIRQ_REND && !r_reg.top_act // [RULE8]
        && !wr_now && !CPU_DI |=> r_reg.gie)
        else $error("return did not set enable");
    a_top_latch: assert property (WDG_EOC && !r_reg.vsel[NIRQ_VS_TSRC] // [RULE21]
        |=> r_reg.top_pnd)
        else $error("top event lost");
    a_nm_sticky: assert property (r_reg.top_nme |=> r_reg.top_nme) // [RULE23]
        else $error("nonmaskable enable cleared");

endmodule : nirq_unit
`default_nettype wire

// [hw/nirq_pkg.sv]
// Summary of operation
// RULE1 - maskable request taken only when its level is strictly below current; top wins
// RULE2 - current_priority_level resets to 7, the lowest priority
// RULE3 - mode bit clear at reset: concurrent, level never changed on acknowledge
// RULE4 - nested acknowledge sets stack bit indexed by the running level
// RULE5 - nested acknowledge then loads level with the acknowledged request's level
// RULE6 - entry: clear enable, swap level, push pc low, high, segment, flags, vector
// RULE7 - entry copies irq segment if saving, else fetch uses irq segment until return
// RULE8 - nested return pops flags, segment, pc high, low, sets enable, restores level
// RULE9 - restore takes lowest set stack bit as level and clears that bit
// RULE10 - without segment save, return reverts to code segment unless still nested
// RULE11 - software should enable interrupts inside routines only in nested mode
// RULE12 - concurrent nesting needs segment save or equal segment registers
// RULE13 - eight external channels in pairs A to D, even and odd
// RULE14 - edge select one sets pending on rising edge, zero on falling edge
// RULE15 - each external channel has its own mask bit blocking its request
// RULE16 - pair bits give even level to even channel, next odd level to odd
// RULE17 - channel a0 from pin zero when select one, else timer watchdog
// RULE18 - channel d0 from pin six when select zero, else clock unit
// RULE19 - top source is nmi pin when select high, else watchdog end of count
// RULE20 - nmi pin edge: rising when top edge select set, else falling
// RULE21 - selected top event sets top_pending
// RULE22 - maskable top path needs top_maskable_enable and global enable both set
// RULE23 - nonmaskable enable is set-only, cleared by reset, ignores global enable
// RULE24 - top routine blocks every other request, including another top request
// RULE25 - top entry and return leave enable, level and stack untouched
package nirq_pkg;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] NIRQ_IDX_CENTRAL = 8'he6;
    localparam logic [7:0] NIRQ_IDX_EDGE    = 8'hf2;
    localparam logic [7:0] NIRQ_IDX_PEND    = 8'hf3;
    localparam logic [7:0] NIRQ_IDX_MASK    = 8'hf4;
    localparam logic [7:0] NIRQ_IDX_PRIO    = 8'hf5;
    localparam logic [7:0] NIRQ_IDX_VSEL    = 8'hf6;
    localparam logic [7:0] NIRQ_IDX_STACK   = 8'hf7;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int NIRQ_CTL_SSE   = 3;
    localparam int NIRQ_CTL_GIE   = 4;
    localparam int NIRQ_CTL_TME   = 5;
    localparam int NIRQ_CTL_TPND  = 6;
    localparam int NIRQ_CTL_MODE  = 7;
    localparam int NIRQ_VS_D0     = 0;
    localparam int NIRQ_VS_A0     = 1;
    localparam int NIRQ_VS_TSRC   = 2;
    localparam int NIRQ_VS_TEDGE  = 3;
    localparam int NIRQ_STK_TNME  = 7;
    localparam int NIRQ_CH_A0     = 0;
    localparam int NIRQ_CH_D0     = 6;

    // ------------------------------------------------------------
    // reset values and the fixed top level vector
    // ------------------------------------------------------------
    localparam logic [2:0] NIRQ_LVL_RST  = 3'h7;
    localparam logic [7:0] NIRQ_VSEL_RST = 8'h06;
    localparam logic [7:0] NIRQ_TOP_VEC  = 8'h00;

    // entry and return sequencer steps
    typedef enum logic [3:0] {
        NIRQ_IDLE, NIRQ_PCL, NIRQ_PCH, NIRQ_SEG, NIRQ_FLG, NIRQ_VEC,
        NIRQ_RFLG, NIRQ_RSEG, NIRQ_RPCH, NIRQ_RPCL, NIRQ_REND
    } nirq_seq_t;

endpackage : nirq_pkg

// [test/nirq_cpu_model.sv]
`timescale 1ns/100ps
`default_nettype none
module nirq_cpu_model
    import nirq_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       irq_req,
    input  wire nirq_seq_t  seq_step,
    input  wire logic       ack_en,
    input  wire logic [1:0] ack_lat,
    input  wire logic       iret_req,
    output logic            cpu_ack,
    output logic            cpu_iret
);
    // ------------------------------------------------------------
    // core stand-in
    // ------------------------------------------------------------
    logic [1:0] wait_cnt;
    logic       iret_q;

    // takes an idle offer after a chosen delay; return is one pulse per request
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cpu_ack  <= 1'b0;
            cpu_iret <= 1'b0;
            iret_q   <= 1'b0;
            wait_cnt <= 2'h0;
        end
        else
        begin
            cpu_iret <= iret_req && !iret_q;
            iret_q   <= iret_req;
            cpu_ack  <= 1'b0;
            wait_cnt <= 2'h0;
            // a slow core lets the offer stand for up to three extra cycles
            if (irq_req && ack_en && seq_step == NIRQ_IDLE && !cpu_ack)
            begin
                if (wait_cnt == ack_lat)
                    cpu_ack <= 1'b1;
                else
                    wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end
endmodule : nirq_cpu_model
`default_nettype wire

// [test/nirq_unit_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module nirq_unit_tb;
    import nirq_pkg::*;
    logic        CLK_SYS, RST_B, WB_CYC, WB_STB, WB_WE, WB_ACK;
    logic [9:0]  WB_ADR;
    logic [3:0]  WB_SEL;
    logic [31:0] WB_DAT_I, WB_DAT_O, rnd;
    logic [7:0]  EXT_PIN, IRQ_VECTOR;
    logic        NMI_PIN, TIMER_IRQ, CLKU_IRQ, WDG_EOC, CPU_ACK, CPU_IRET, CPU_EN_IRQ, CPU_DI;
    logic        IRQ_REQ, IRQ_TOP, SEG_LOAD, FETCH_IRQ_SEG, ack_en, iret_req;
    logic [1:0]  ack_lat;
    nirq_seq_t   SEQ_STEP;
    logic [31:0] rd_q [$];
    int          fails, num_checks, seed, seg_loads;

    nirq_unit i_nirq_unit (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .WB_CYC(WB_CYC),
        .WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(WB_SEL),
        .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK), .EXT_PIN(EXT_PIN),
        .NMI_PIN(NMI_PIN), .TIMER_IRQ(TIMER_IRQ), .CLKU_IRQ(CLKU_IRQ), .WDG_EOC(WDG_EOC),
        .CPU_ACK(CPU_ACK), .CPU_IRET(CPU_IRET), .CPU_EN_IRQ(CPU_EN_IRQ), .CPU_DI(CPU_DI),
        .IRQ_REQ(IRQ_REQ), .IRQ_TOP(IRQ_TOP), .IRQ_VECTOR(IRQ_VECTOR),
        .SEQ_STEP(SEQ_STEP), .SEG_LOAD(SEG_LOAD), .FETCH_IRQ_SEG(FETCH_IRQ_SEG));
    nirq_cpu_model i_nirq_cpu_model (.clk_sys(CLK_SYS), .rst_b(RST_B), .irq_req(IRQ_REQ),
        .seq_step(SEQ_STEP), .ack_en(ack_en), .ack_lat(ack_lat), .iret_req(iret_req),
        .cpu_ack(CPU_ACK), .cpu_iret(CPU_IRET));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial
    begin
        CLK_SYS = 1'b0;
        forever #20 CLK_SYS = ~CLK_SYS;
    end

    task summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // one classic cycle; held until ack is sampled, then released for a cycle
    task wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        WB_CYC   <= 1'b1;
        WB_STB   <= 1'b1;
        WB_WE    <= we;
        WB_ADR   <= {idx, 2'b00};
        WB_SEL   <= 4'hf;
        WB_DAT_I <= {24'h00_0000, d};
        do begin @(posedge CLK_SYS); n++; end while (WB_ACK !== 1'b1 && n < 50);
        WB_CYC <= 1'b0;
        WB_STB <= 1'b0;
        if (n >= 50) begin fails++; summarize(); end
    endtask : wb

    task wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d);
    endtask : wr

    // the note goes in the queue; the watcher compares it
    task rd(input logic [7:0] idx, input logic [7:0] exp);
        rd_q.push_back({24'h00_0000, exp});
        wb(1'b0, idx, 8'h00);
    endtask : rd

    // sequencer steps must follow one another a cycle apart
    task steps(input nirq_seq_t e [5]);
        int n;
        n = 0;
        do begin @(posedge CLK_SYS); n++; end while (SEQ_STEP !== e[0] && n < 40);
        ack_en <= 1'b0;
        if (n >= 40) begin fails++; summarize(); end
        for (int i = 0; i < 5; i++)
        begin
            check("step", 32'(SEQ_STEP), 32'(e[i]));
            @(posedge CLK_SYS);
        end
    endtask : steps

    task do_iret();
        iret_req <= 1'b1;
        @(posedge CLK_SYS);
        iret_req <= 1'b0;
    endtask : do_iret

    // read data is taken at the ack edge only
    always @(posedge CLK_SYS)
        if (WB_ACK === 1'b1 && WB_WE === 1'b0 && rd_q.size() > 0)
            check("rdata", WB_DAT_O, rd_q.pop_front());

    // segment copy pulses seen at the vector step
    always @(posedge CLK_SYS)
        if (SEG_LOAD === 1'b1)
            seg_loads++;

    initial
    begin
        repeat (20000) @(posedge CLK_SYS);
        fails++;
        summarize();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {RST_B, WB_CYC, WB_STB, WB_WE, NMI_PIN, TIMER_IRQ, CLKU_IRQ, WDG_EOC} = 8'h00;
        {CPU_EN_IRQ, CPU_DI, ack_en, iret_req} = 4'h0;
        {WB_ADR, WB_SEL, WB_DAT_I, EXT_PIN} = '0;
        seed = 10;
        rnd = $random(seed);
        ack_lat = rnd[1:0];
        repeat (2) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        rd(NIRQ_IDX_CENTRAL, 8'h07);
        rd(NIRQ_IDX_VSEL, NIRQ_VSEL_RST);
        rd(NIRQ_IDX_STACK, 8'h00);
        rd(8'h10, 8'h00);
        $display("test reset done");
        rnd = $random(seed);
        wr(NIRQ_IDX_EDGE, rnd[7:0]);
        rd(NIRQ_IDX_EDGE, rnd[7:0]);
        wr(NIRQ_IDX_EDGE, 8'h41);
        wr(NIRQ_IDX_PEND, 8'h00);
        EXT_PIN <= 8'h43;
        repeat (6) @(posedge CLK_SYS);
        rd(NIRQ_IDX_PEND, 8'h41);
        EXT_PIN <= 8'h00;
        repeat (6) @(posedge CLK_SYS);
        rd(NIRQ_IDX_PEND, 8'h43);
        wr(NIRQ_IDX_PEND, 8'h00);
        wr(NIRQ_IDX_VSEL, 8'h05);
        TIMER_IRQ <= 1'b1;
        CLKU_IRQ  <= 1'b1;
        @(posedge CLK_SYS);
        TIMER_IRQ <= 1'b0;
        CLKU_IRQ  <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        rd(NIRQ_IDX_PEND, 8'h41);
        wr(NIRQ_IDX_VSEL, NIRQ_VSEL_RST);
        wr(NIRQ_IDX_PEND, 8'h00);
        $display("test edges done");
        // nested: channel a0 at level 2 taken over a routine at level 5
        wr(NIRQ_IDX_PRIO, 8'h40);
        wr(NIRQ_IDX_CENTRAL, 8'h95);
        wr(NIRQ_IDX_MASK, 8'h40);
        EXT_PIN <= 8'h01;
        repeat (6) @(posedge CLK_SYS);
        check("req", 32'(IRQ_REQ), 32'h0000_0000);
        wr(NIRQ_IDX_CENTRAL, 8'h92);
        wr(NIRQ_IDX_MASK, 8'h80);
        repeat (2) @(posedge CLK_SYS);
        check("req", 32'(IRQ_REQ), 32'h0000_0000);
        wr(NIRQ_IDX_CENTRAL, 8'h95);
        repeat (2) @(posedge CLK_SYS);
        check("req", 32'(IRQ_REQ), 32'h0000_0001);
        ack_en <= 1'b1;
        steps('{NIRQ_PCL, NIRQ_PCH, NIRQ_FLG, NIRQ_VEC, NIRQ_IDLE});
        check("segld", seg_loads, 32'h0000_0000);
        check("fseg", 32'(FETCH_IRQ_SEG), 32'h0000_0001);
        rd(NIRQ_IDX_CENTRAL, 8'h82);
        rd(NIRQ_IDX_STACK, 8'h20);
        do_iret();
        steps('{NIRQ_RFLG, NIRQ_RPCH, NIRQ_RPCL, NIRQ_REND, NIRQ_IDLE});
        rd(NIRQ_IDX_CENTRAL, 8'h95);
        rd(NIRQ_IDX_STACK, 8'h00);
        check("fseg", 32'(FETCH_IRQ_SEG), 32'h0000_0000);
        CPU_DI <= 1'b1;
        @(posedge CLK_SYS);
        CPU_DI <= 1'b0;
        rd(NIRQ_IDX_CENTRAL, 8'h85);
        CPU_EN_IRQ <= 1'b1; // nested mode only
        @(posedge CLK_SYS);
        CPU_EN_IRQ <= 1'b0;
        rd(NIRQ_IDX_CENTRAL, 8'h95);
        $display("test nested done");
        // concurrent with segment save: level kept, segment pushed
        wr(NIRQ_IDX_CENTRAL, 8'h1d);
        wr(NIRQ_IDX_PEND, 8'h01);
        ack_en <= 1'b1;
        steps('{NIRQ_PCL, NIRQ_PCH, NIRQ_SEG, NIRQ_FLG, NIRQ_VEC});
        check("segld", seg_loads, 32'h0000_0001);
        rd(NIRQ_IDX_CENTRAL, 8'h0d);
        check("fseg", 32'(FETCH_IRQ_SEG), 32'h0000_0000);
        do_iret();
        steps('{NIRQ_RFLG, NIRQ_RSEG, NIRQ_RPCH, NIRQ_RPCL, NIRQ_REND});
        rd(NIRQ_IDX_CENTRAL, 8'h1d);
        $display("test concurrent done");
        // top level from the nmi pin, rising edge, nonmaskable enable
        wr(NIRQ_IDX_CENTRAL, 8'h95);
        wr(NIRQ_IDX_STACK, 8'h80);
        wr(NIRQ_IDX_STACK, 8'h00);
        rd(NIRQ_IDX_STACK, 8'h80);
        wr(NIRQ_IDX_VSEL, 8'h0e);
        NMI_PIN <= 1'b1;
        repeat (6) @(posedge CLK_SYS);
        rd(NIRQ_IDX_CENTRAL, 8'hd5);
        check("top", 32'(IRQ_TOP), 32'h0000_0001);
        check("vec", 32'(IRQ_VECTOR), 32'(NIRQ_TOP_VEC));
        ack_en <= 1'b1;
        steps('{NIRQ_PCL, NIRQ_PCH, NIRQ_FLG, NIRQ_VEC, NIRQ_IDLE});
        rd(NIRQ_IDX_CENTRAL, 8'h95);
        rd(NIRQ_IDX_STACK, 8'h80);
        wr(NIRQ_IDX_PEND, 8'h01);
        repeat (3) @(posedge CLK_SYS);
        check("req", 32'(IRQ_REQ), 32'h0000_0000);
        do_iret();
        steps('{NIRQ_RFLG, NIRQ_RPCH, NIRQ_RPCL, NIRQ_REND, NIRQ_IDLE});
        rd(NIRQ_IDX_CENTRAL, 8'h95);
        repeat (2) @(posedge CLK_SYS);
        check("req", 32'(IRQ_REQ), 32'h0000_0001);
        $display("test top done");
        // watchdog end of count as top source; external offer shows the vector base
        wr(NIRQ_IDX_VSEL, 8'ha2);
        repeat (2) @(posedge CLK_SYS);
        check("vec", 32'(IRQ_VECTOR), 32'h0000_00a0);
        WDG_EOC <= 1'b1;
        @(posedge CLK_SYS);
        WDG_EOC <= 1'b0;
        rd(NIRQ_IDX_CENTRAL, 8'hd5);
        check("top", 32'(IRQ_TOP), 32'h0000_0001);
        $display("test watchdog done");
        summarize();
    end
endmodule : nirq_unit_tb
`default_nettype wire
